// File: led_dimmer_cfg.svh
`ifndef LED_DIMMER_CFG_SVH
`define LED_DIMMER_CFG_SVH

// register offsets on the serial host link
`define REG_FLASH 8'h50
`define REG_RED 8'h51
`define REG_GREEN 8'h52
`define REG_BLUE 8'h53
`define REG_RESET 8'h00
// writable bits of each register, everything else reads zero
`define MASK_FLASH 8'h7f
`define MASK_RED 8'h7f
`define MASK_GREEN 8'hdf
`define MASK_BLUE 8'h1f
// field positions
`define CHAN_ON_BIT 7
`define PHASE_BIT 6
`define ISET_MSB 6
`define ISET_LSB 5
`define LEVEL_MSB 4
`define ON_MSB 6
`define ON_LSB 4
`define PER_MSB 3
// codes
`define FULL_LEVEL 5'h1f
`define PER_ALWAYS 4'hf
// timing, as printed
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define SHIFT_US 200
`define STEP_DIV_X10 54
`define UNITS_PER_FRAME 34
`define SLOTS_USED 6'h20
`define PER_BASE_MS 1000
`define PER_STEP_MS 500
// link address, value is arbitrary
`define DEV_ADDR 7'h2a

`endif

// File: led_dimmer_pkg.sv
package led_dimmer_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_REG = 3'b010,
        ST_WR = 3'b011,
        ST_RD = 3'b100
    } link_state_t;

endpackage

// File: serial_reg_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_dimmer_cfg.svh"

module serial_reg_port
    import led_dimmer_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_drive_n,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    logic [2:0] sync [2];
    logic [1:0] lvl, lvl_d, next_lvl;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    link_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic ack, next_ack, rw, next_rw, nack, next_nack, next_drive_n, next_wr;
    logic [7:0] rx, next_rx, tx, next_tx, next_addr, next_wdata;

    // three-stage synchronisers; a level only counts once stages two and three agree
    for (genvar p = 0; p < 2; p++) begin : g_sync
        always_comb begin
            next_lvl[p] = (sync[p][1] == sync[p][2]) ? sync[p][2] : lvl[p];
        end
        always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
                sync[p] <= 3'h7;
                lvl[p] <= 1'h1;
                lvl_d[p] <= 1'h1;
            end else begin
                sync[p] <= {sync[p][1:0], (p == 0) ? i_scl : i_sda};
                lvl[p] <= next_lvl[p];
                lvl_d[p] <= lvl[p];
            end
        end
    end

    assign scl_rise = lvl[0] & ~lvl_d[0];
    assign scl_fall = ~lvl[0] & lvl_d[0];
    assign start_ev = lvl[0] & lvl_d[0] & ~lvl[1] & lvl_d[1];
    assign stop_ev = lvl[0] & lvl_d[0] & lvl[1] & ~lvl_d[1];

    // byte engine: bits taken on scl rise, answers changed on scl fall
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_ack = ack;
        next_rw = rw;
        next_nack = nack;
        next_rx = rx;
        next_tx = tx;
        next_addr = o_addr;
        next_wdata = o_wdata;
        next_drive_n = o_sda_drive_n;
        next_wr = 1'h0;
        if (start_ev) begin
            next_state = ST_DEV;
            next_cnt = 4'h0;
            next_ack = 1'h0;
            next_drive_n = 1'h1;
        end else if (stop_ev) begin
            next_state = ST_IDLE;
            next_drive_n = 1'h1;
        end else if (state != ST_IDLE && scl_rise) begin
            if (!ack) begin
                next_rx = {rx[6:0], lvl[1]};
                next_cnt = cnt + 4'h1;
            end else begin
                next_nack = lvl[1];
            end
        end else if (state != ST_IDLE && scl_fall) begin
            if (!ack && cnt == 4'h8) begin
                next_ack = 1'h1;
                next_drive_n = 1'h0;
                unique case (state)
                    ST_DEV: begin
                        next_rw = rx[0];
                        if (rx[7:1] != DEV_ADDR) begin
                            next_state = ST_IDLE;
                            next_drive_n = 1'h1;
                        end
                    end
                    ST_REG: next_addr = rx;
                    ST_WR: begin
                        next_wdata = rx;
                        next_wr = 1'h1;
                    end
                    ST_RD: begin
                        next_drive_n = 1'h1;
                        next_addr = o_addr + 8'h1;
                    end
                    default: next_state = ST_IDLE;
                endcase
            end else if (ack) begin
                next_ack = 1'h0;
                next_cnt = 4'h0;
                next_drive_n = 1'h1;
                unique case (state)
                    ST_DEV: begin
                        next_state = rw ? ST_RD : ST_REG;
                        if (rw) begin
                            next_tx = i_rdata;
                            next_drive_n = i_rdata[7];
                        end
                    end
                    ST_REG: next_state = ST_WR;
                    ST_WR: next_addr = o_addr + 8'h1;
                    ST_RD: begin
                        if (nack) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_tx = i_rdata;
                            next_drive_n = i_rdata[7];
                        end
                    end
                    default: next_state = ST_IDLE;
                endcase
            end else if (state == ST_RD && cnt != 4'h0) begin
                next_tx = {tx[6:0], 1'h0};
                next_drive_n = tx[6];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            ack <= 1'h0;
            rw <= 1'h0;
            nack <= 1'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            o_addr <= 8'h00;
            o_wdata <= 8'h00;
            o_sda_drive_n <= 1'h1;
            o_wr <= 1'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            ack <= next_ack;
            rw <= next_rw;
            nack <= next_nack;
            rx <= next_rx;
            tx <= next_tx;
            o_addr <= next_addr;
            o_wdata <= next_wdata;
            o_sda_drive_n <= next_drive_n;
            o_wr <= next_wr;
        end
    end

endmodule

`default_nettype wire

// File: tricolor_led_flash_dimmer.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_dimmer_cfg.svh"

// How it works
// - three sink outputs, red green blue, share one set of channel settings
// - outputs only act while channel_on is set, otherwise all off
// - sink_current_code in red register bits 6:5 sets current for all three
// - flashing mode timed only by flash_timing_cfg, on-time then off interval
// - flash_on_time_code picks 0.10 to 0.60 s on-time
// - flash_period_code picks 1.0 to 8.0 s period; code 15 means always on
// - during on-time each colour is modulated by its own 5-bit intensity
// - modulation is spread pulses repeating near 160 Hz, not one pulse
// - one colour starts its pulses 200 us after the other two
// - phase_select zero: red and blue in phase, green shifted
// - phase_select one: red and green in phase, blue shifted
// - intensity codes up to 30 give code divided by 5.4 ms on-time
// - intensity code 31 holds the colour on without modulation
module tricolor_led_flash_dimmer
    import led_dimmer_pkg::*;
#(
    parameter int MS_CYC = `MS_NS / `CLK_PERIOD_NS,
    parameter int UNIT_CYC = (`MS_NS * 10) / (`STEP_DIV_X10 * `CLK_PERIOD_NS),
    parameter int SHIFT_CYC = (`SHIFT_US * 1000) / `CLK_PERIOD_NS,
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_drive_n,
    output logic o_sink_out_a,
    output logic o_sink_out_b,
    output logic o_sink_out_c,
    output logic [1:0] o_sink_current_code
);
    localparam int FRAME_CYC = `UNITS_PER_FRAME * UNIT_CYC;
    localparam int LAG_POS = FRAME_CYC - SHIFT_CYC;
    localparam logic [5:0] LAG_IDX = 6'(LAG_POS / UNIT_CYC);
    localparam logic [16:0] LAG_CYC = 17'(LAG_POS % UNIT_CYC);

    logic reg_wr;
    logic [7:0] reg_addr, reg_wdata, rd_data;
    logic [7:0] flash_timing_cfg, red_level_and_current, green_level_enable_phase, blue_level;
    logic [7:0] next_flash, next_red, next_green, next_blue;
    logic channel_on, phase_select;
    logic [2:0] flash_on_time_code;
    logic [3:0] flash_period_code;
    logic [4:0] intensity_first_colour, intensity_second_colour, intensity_third_colour;

    serial_reg_port #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_drive_n(o_sda_drive_n),
        .o_wr(reg_wr),
        .o_addr(reg_addr),
        .o_wdata(reg_wdata),
        .i_rdata(rd_data)
    );

    assign channel_on = green_level_enable_phase[`CHAN_ON_BIT];
    assign phase_select = green_level_enable_phase[`PHASE_BIT];
    assign flash_on_time_code = flash_timing_cfg[`ON_MSB:`ON_LSB];
    assign flash_period_code = flash_timing_cfg[`PER_MSB:0];
    assign intensity_first_colour = red_level_and_current[`LEVEL_MSB:0];
    assign intensity_second_colour = green_level_enable_phase[`LEVEL_MSB:0];
    assign intensity_third_colour = blue_level[`LEVEL_MSB:0];

    // register writes; masking keeps spare bits at zero so reads need no extra gating
    always_comb begin
        next_flash = flash_timing_cfg;
        next_red = red_level_and_current;
        next_green = green_level_enable_phase;
        next_blue = blue_level;
        if (reg_wr) begin
            unique case (reg_addr)
                `REG_FLASH: next_flash = reg_wdata & `MASK_FLASH;
                `REG_RED: next_red = reg_wdata & `MASK_RED;
                `REG_GREEN: next_green = reg_wdata & `MASK_GREEN;
                `REG_BLUE: next_blue = reg_wdata & `MASK_BLUE;
                default: ; // other addresses belong elsewhere
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            flash_timing_cfg <= `REG_RESET;
            red_level_and_current <= `REG_RESET;
            green_level_enable_phase <= `REG_RESET;
            blue_level <= `REG_RESET;
        end else begin
            flash_timing_cfg <= next_flash;
            red_level_and_current <= next_red;
            green_level_enable_phase <= next_green;
            blue_level <= next_blue;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        unique case (reg_addr)
            `REG_FLASH: rd_data = flash_timing_cfg;
            `REG_RED: rd_data = red_level_and_current;
            `REG_GREEN: rd_data = green_level_enable_phase;
            `REG_BLUE: rd_data = blue_level;
            default: rd_data = 8'h00;
        endcase
    end

    // two pulse timebases of 1/5.4 ms units; the second lags by the shift time
    logic [16:0] unit_cyc [2];
    logic [16:0] next_unit_cyc [2];
    logic [5:0] unit_idx [2];
    logic [5:0] next_unit_idx [2];

    for (genvar t = 0; t < 2; t++) begin : g_tb
        always_comb begin
            next_unit_cyc[t] = unit_cyc[t] + 17'h1;
            next_unit_idx[t] = unit_idx[t];
            if (unit_cyc[t] == 17'(UNIT_CYC - 1)) begin
                next_unit_cyc[t] = 17'h0;
                next_unit_idx[t] = (unit_idx[t] == 6'(`UNITS_PER_FRAME - 1)) ?
                                   6'h0 : unit_idx[t] + 6'h1;
            end
        end
        always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
                unit_cyc[t] <= (t == 0) ? 17'h0 : LAG_CYC;
                unit_idx[t] <= (t == 0) ? 6'h0 : LAG_IDX;
            end else begin
                unit_cyc[t] <= next_unit_cyc[t];
                unit_idx[t] <= next_unit_idx[t];
            end
        end
    end

    // on-time of the flash, in milliseconds
    function automatic logic [12:0] on_ms(input logic [2:0] code);
        unique case (code)
            3'h0: on_ms = 13'd100;
            3'h1: on_ms = 13'd150;
            3'h2: on_ms = 13'd200;
            3'h3: on_ms = 13'd250;
            3'h4: on_ms = 13'd300;
            3'h5: on_ms = 13'd400;
            3'h6: on_ms = 13'd500;
            3'h7: on_ms = 13'd600;
        endcase
    endfunction

    // bit-reversed slot order scatters the lit units evenly over the frame
    function automatic logic lit(input logic [5:0] idx, input logic [4:0] lvl);
        logic [4:0] rev;
        rev = {idx[0], idx[1], idx[2], idx[3], idx[4]};
        lit = (lvl == `FULL_LEVEL) || ((idx < `SLOTS_USED) && (rev < lvl));
    endfunction

    // flash timer: a millisecond enable pulse drives the ms counter
    logic [17:0] ms_div, next_ms_div;
    logic [12:0] ms_cnt, next_ms_cnt, period_ms;
    logic flash_window, next_flash_window;

    assign period_ms = 13'(`PER_BASE_MS + flash_period_code * `PER_STEP_MS);

    always_comb begin
        next_ms_div = 18'h0;
        next_ms_cnt = 13'h0;
        next_flash_window = 1'h0;
        if (channel_on) begin
            next_ms_div = (ms_div == 18'(MS_CYC - 1)) ? 18'h0 : ms_div + 18'h1;
            next_ms_cnt = ms_cnt;
            if (ms_div == 18'(MS_CYC - 1)) begin
                next_ms_cnt = (ms_cnt >= period_ms - 13'h1) ? 13'h0 : ms_cnt + 13'h1;
            end
            next_flash_window = (flash_period_code == `PER_ALWAYS) ||
                                (ms_cnt < on_ms(flash_on_time_code));
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ms_div <= 18'h0;
            ms_cnt <= 13'h0;
            flash_window <= 1'h0;
        end else begin
            ms_div <= next_ms_div;
            ms_cnt <= next_ms_cnt;
            flash_window <= next_flash_window;
        end
    end

    // sink outputs; red always rides the leading timebase
    logic next_out_a, next_out_b, next_out_c;

    always_comb begin
        next_out_a = channel_on && flash_window &&
                     lit(unit_idx[0], intensity_first_colour);
        next_out_b = channel_on && flash_window &&
                     lit(unit_idx[phase_select ? 0 : 1], intensity_second_colour);
        next_out_c = channel_on && flash_window &&
                     lit(unit_idx[phase_select ? 1 : 0], intensity_third_colour);
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sink_out_a <= 1'h0;
            o_sink_out_b <= 1'h0;
            o_sink_out_c <= 1'h0;
            o_sink_current_code <= 2'h0;
        end else begin
            o_sink_out_a <= next_out_a;
            o_sink_out_b <= next_out_b;
            o_sink_out_c <= next_out_c;
            o_sink_current_code <= red_level_and_current[`ISET_MSB:`ISET_LSB];
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    chk_off_disabled: assert property (!channel_on |=>
        !o_sink_out_a && !o_sink_out_b && !o_sink_out_c) else $error("output lit while off");
    chk_current_code: assert property (##1 o_sink_current_code ==
        $past(red_level_and_current[`ISET_MSB:`ISET_LSB])) else $error("sink code wrong");
    chk_off_window: assert property (!flash_window |=>
        !o_sink_out_a && !o_sink_out_b && !o_sink_out_c) else $error("lit outside flash");
    chk_window_ends: assert property (channel_on && flash_period_code != `PER_ALWAYS &&
        ms_cnt >= on_ms(flash_on_time_code) |=> !flash_window) else $error("flash too long");
    chk_always_on: assert property (channel_on && flash_period_code == `PER_ALWAYS
        |=> flash_window) else $error("always-on period not held");
    chk_frame_wrap: assert property (unit_idx[0] == 6'(`UNITS_PER_FRAME - 1) &&
        unit_cyc[0] == 17'(UNIT_CYC - 1) |=> unit_idx[0] == 6'h0) else $error("frame wrap");
    chk_lag_offset: assert property (unit_idx[0] == 6'h0 && unit_cyc[0] == 17'h0
        |-> unit_idx[1] == LAG_IDX && unit_cyc[1] == LAG_CYC) else $error("lag lost");
    chk_red_blue_phase: assert property (!phase_select &&
        intensity_first_colour == intensity_third_colour |=> o_sink_out_a == o_sink_out_c)
        else $error("red and blue out of phase");
    chk_red_green_phase: assert property (phase_select &&
        intensity_first_colour == intensity_second_colour |=> o_sink_out_a == o_sink_out_b)
        else $error("red and green out of phase");
    chk_level_zero: assert property (intensity_first_colour == 5'h0 |=>
        !o_sink_out_a) else $error("zero level lit");
    chk_full_level: assert property (channel_on && flash_window &&
        intensity_first_colour == `FULL_LEVEL |=> o_sink_out_a) else $error("full level dark");
    chk_spare_zero: assert property (!flash_timing_cfg[7] && !red_level_and_current[7] &&
        !green_level_enable_phase[5] && blue_level[7:5] == 3'h0) else $error("spare bit set");

    cov_flash_off: cover property (channel_on && flash_window ##1 !flash_window);
    cov_shift_blue: cover property (phase_select && o_sink_out_a && !o_sink_out_c);
    cov_reg_write: cover property (reg_wr && reg_addr == `REG_GREEN);

endmodule

`default_nettype wire

// File: led_model.sv
`timescale 1ns/1ps
`default_nettype none

// external red, green and blue leds: passive loads, so the model only watches
// the sinks, counting lit clocks and noting the clock of each turn-on
module led_model (
    input wire logic i_sys_clk,
    input wire logic i_clear,
    input wire logic [2:0] i_sink,
    output logic [2:0][15:0] o_lit,
    output logic [2:0][31:0] o_rise
);
    logic [31:0] cyc = '0;
    logic [2:0] prev = '0;

    // lit counts restart on clear so any window of clocks can be measured
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 32'h1;
        prev <= i_sink;
        for (int i = 0; i < 3; i++) begin
            o_lit[i] <= i_clear ? 16'h0 : o_lit[i] + 16'(i_sink[i]);
            if (i_sink[i] && !prev[i]) begin
                o_rise[i] <= cyc;
            end
        end
    end
endmodule

`default_nettype wire

// File: test_tricolor_led_flash_dimmer.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_dimmer_cfg.svh"

module test_tricolor_led_flash_dimmer;
    localparam int FRAME = 340;
    localparam logic [4:0][7:0] ADDR = {8'h40, 8'h53, 8'h52, 8'h51, 8'h50};
    localparam logic [4:0][7:0] MASK = {8'h00, 8'h1f, 8'hdf, 8'h7f, 8'h7f};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic clr = 1'b0;
    logic sda;
    logic drive_n;
    logic out_a;
    logic out_b;
    logic out_c;
    logic [1:0] cur;
    logic [2:0][15:0] lit;
    logic [2:0][31:0] rise;
    logic [2:0][15:0] snap;
    logic [15:0] exp_q [$];
    logic [15:0] res_val;
    logic [15:0] rnd = 16'hf32f;
    string res_name;
    event res_ev;
    int failures = 0;
    int n_tests = 0;

    // open-drain data line: released level is the pull-up
    assign sda = sda_m & drive_n;

    always #2.5 clk = ~clk;

    tricolor_led_flash_dimmer #(.MS_CYC(20), .UNIT_CYC(10), .SHIFT_CYC(12)) uut (
        .i_sys_clk(clk),
        .i_rst(rst),
        .i_scl(scl),
        .i_sda(sda),
        .o_sda_drive_n(drive_n),
        .o_sink_out_a(out_a),
        .o_sink_out_b(out_b),
        .o_sink_out_c(out_c),
        .o_sink_current_code(cur)
    );

    led_model leds (
        .i_sys_clk(clk),
        .i_clear(clr),
        .i_sink({out_c, out_b, out_a}),
        .o_lit(lit),
        .o_rise(rise)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0);
    endfunction

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // scl low and high phases stay well above the 4 clocks the port needs
    task automatic bit_out(input logic b);
        sda_m = b;
        idle(5);
        scl = 1'b1;
        idle(10);
        scl = 1'b0;
        idle(5);
    endtask

    task automatic bit_in(output logic b);
        sda_m = 1'b1;
        idle(5);
        scl = 1'b1;
        idle(5);
        b = sda;
        idle(5);
        scl = 1'b0;
        idle(5);
    endtask

    // data rises before clock so a repeated start is never seen as a stop
    task automatic start_c;
        sda_m = 1'b1;
        idle(5);
        scl = 1'b1;
        idle(10);
        sda_m = 1'b0;
        idle(10);
        scl = 1'b0;
        idle(5);
    endtask

    task automatic stop_c;
        sda_m = 1'b0;
        idle(5);
        scl = 1'b1;
        idle(10);
        sda_m = 1'b1;
        idle(10);
    endtask

    task automatic byte_out(input logic [7:0] d);
        logic ack;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(ack);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start_c();
        byte_out({`DEV_ADDR, 1'b0});
        byte_out(a);
        byte_out(d);
        stop_c();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        start_c();
        byte_out({`DEV_ADDR, 1'b0});
        byte_out(a);
        start_c();
        byte_out({`DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(1'b1);
        stop_c();
    endtask

    // counts are frozen into snap at once, since the model keeps counting while results post
    task automatic measure(input int n);
        clr = 1'b1;
        idle(1);
        clr = 1'b0;
        idle(n);
        snap = lit;
    endtask

    task automatic expect_val(input logic [15:0] e);
        exp_q.push_back(e);
    endtask

    // one clock between results so the watcher never misses one
    task automatic post(input string name, input logic [15:0] v);
        res_name = name;
        res_val = v;
        ->res_ev;
        @(negedge clk);
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] e);
        n_tests++;
        if (seen !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, e, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(res_ev) begin
        check(res_name, res_val, exp_q.pop_front());
    end

    initial begin
        logic [7:0] d;
        logic [4:0] lv [3];
        logic [31:0] r0;
        int w;
        logic en;
        idle(4);
        rst = 1'b0;
        idle(4);
        // reset values, then all ones written back through the bit masks
        for (int i = 0; i < 5; i++) begin
            rd(ADDR[i], d);
            expect_val(16'h0);
            post("reset value", {8'h0, d});
            wr(ADDR[i], 8'hff);
            rd(ADDR[i], d);
            expect_val({8'h0, MASK[i]});
            post("readback", {8'h0, d});
        end
        // all-ones setup: always-on window, level 31 on every colour
        measure(FRAME);
        for (int j = 0; j < 3; j++) begin
            expect_val(16'(FRAME));
            post("full lit", snap[j]);
        end
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h51, {1'b0, 2'(c), 5'h1f});
            idle(4);
            expect_val(16'(c));
            post("current code", {14'h0, cur});
        end
        $display("test current done");
        // random levels; the last pass turns the channel off
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            lv[0] = 5'(rnd[4:0] % 5'd31);
            lv[1] = 5'(rnd[9:5] % 5'd31);
            lv[2] = 5'(rnd[14:10] % 5'd31);
            en = (k != 3);
            wr(8'h51, {3'b001, lv[0]});
            wr(8'h52, {en, 1'(k), 1'b0, lv[1]});
            wr(8'h53, {3'b000, lv[2]});
            idle(4);
            measure(FRAME);
            for (int j = 0; j < 3; j++) begin
                expect_val(en ? 16'(lv[j]) * 16'd10 : 16'h0);
                post("lit per frame", snap[j]);
            end
        end
        $display("test levels done");
        // level 1 lights one unit per frame, so turn-on clocks show the lag
        for (int ph = 0; ph < 2; ph++) begin
            wr(8'h51, 8'h21);
            wr(8'h53, 8'h01);
            wr(8'h52, {1'b1, 1'(ph), 6'h01});
            r0 = rise[0];
            w = 0;
            while (rise[0] === r0 && w < 400) begin
                idle(1);
                w++;
            end
            idle(20);
            expect_val(ph == 1 ? 16'd0 : 16'd12);
            post("green lag", 16'(rise[1] - rise[0]));
            expect_val(ph == 1 ? 16'd12 : 16'd0);
            post("blue lag", 16'(rise[2] - rise[0]));
        end
        $display("test phase done");
        // channel toggled so the flash count restarts under the new timing
        for (int f = 0; f < 2; f++) begin
            wr(8'h52, 8'h00);
            wr(8'h50, f == 0 ? 8'h00 : 8'h70);
            wr(8'h51, 8'h3f);
            wr(8'h52, 8'h9f);
            measure(20000);
            expect_val(f == 0 ? 16'd2000 : 16'd12000);
            post("flash lit", snap[0]);
        end
        $display("test flash done");
        end_of_test();
    end

    // runs out well after the roughly 70000 clocks the tests need
    initial begin
        #600000;
        failures++;
        end_of_test();
    end
endmodule

`default_nettype wire
